// file: l2_learn_defines.svh
`ifndef L2_LEARN_DEFINES_SVH
`define L2_LEARN_DEFINES_SVH

// Register word indices; byte address is four times the index
`define IDX_OVF       22'h00013a
`define IDX_CTRL      22'h000140
`define IDX_WMARK     22'h000141
`define IDX_IRQ_STAT  22'h000150
`define IDX_IRQ_MASK  22'h000151
`define IDX_RESULT    22'h00417d
`define IDX_DEST      22'h1120ab

// Reset values
`define RST_CTRL      1'b1
`define RST_WMARK     6'h00
`define RST_DEST      49'h0
`define RST_OVF       65'h0
`define RST_IRQ       2'h0

// Field positions
`define DEST_EN_BIT   48
`define OVF_VALID_BIT 0
`define RES_VALID_BIT 123
`define ORIGIN_BIT    122
`define IRQ_WM_BIT    0
`define IRQ_OVF_BIT   1

// Bus answers
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// file: l2_learn_pkg.sv
package l2_learn_pkg;
    typedef logic [23:0]  axi_addr_t;
    typedef logic [31:0]  axi_data_t;
    typedef logic [3:0]   axi_strb_t;
    typedef logic [1:0]   axi_resp_t;
    typedef logic [21:0]  word_idx_t;
    typedef logic [122:0] learn_entry_t;
    typedef logic [47:0]  station_addr_t;
    typedef logic [11:0]  fail_gid_t;
    typedef logic [3:0]   port_num_t;
    typedef logic [1:0]   irq_vec_t;
endpackage

// file: result_store.sv
`timescale 1ns/1ps
module result_store #(
    parameter int WIDTH = 123,
    parameter int DEPTH = 64,
    parameter int CW    = $clog2(DEPTH + 1),
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] din,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] head,
    output logic      [CW-1:0]    count_q,
    output logic                  in_ready_q,
    output logic                  empty
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_d;

    assign head    = mem_q[rd_ptr_q];
    assign empty   = (count_q == '0);
    assign count_d = CW'(count_q + CW'(push) - CW'(pop));

    always_ff @(posedge aclk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= din;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            count_q    <= '0;
            in_ready_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_q + 1'b1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_q + 1'b1);
            end
            count_q    <= count_d;
            // Registered ready from the next count: no slot of headroom, all DEPTH slots fill
            in_ready_q <= (count_d < CW'(DEPTH));
        end
    end
endmodule

// file: l2_learning_report_fifo.sv
// Operation
// - Programmed 48-bit destination address marks injected learning packets.
// - Injected packets accepted only while enable bit 48 is set.
// - Reading the result register returns the head entry and pops it.
// - With write-back on, every entry is written to the table.
// - With write-back off, hardware results go only to the FIFO.
// - Entry: station address 47:0, group id 63:48, table index 78:64.
// - Entry: unicast flag 79, port or pointer 88:80, drop 89.
// - Entry: action flags, tunnel fields 92..102, cpu_tag_info 118:103.
// - Entry status 121:119 from aging or collision table.
// - Bit 122 gives origin: 0 hardware, 1 injected software.
// - Bit 123 reads 1 when data valid, 0 when empty.
// - Watermark interrupt when occupancy after push exceeds level.
// - Learning failure recorded in overflow register, valid bit 0 set.
// - Valid overflow record is overwritten only by a failure in the cycle of its clear.
// - Record: address 48:1, group id 60:49, ingress port 64:61.
// - Write-back control bit, reset one, selects table write of results.
`timescale 1ns/1ps
`include "l2_learn_defines.svh"
module l2_learning_report_fifo #(
    parameter int DEPTH = 64
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire l2_learn_pkg::axi_addr_t       awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire l2_learn_pkg::axi_data_t       wdata,
    input  wire l2_learn_pkg::axi_strb_t       wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output l2_learn_pkg::axi_resp_t            bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    input  wire l2_learn_pkg::axi_addr_t       araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output l2_learn_pkg::axi_data_t            rdata,
    output l2_learn_pkg::axi_resp_t            rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    input  wire logic                          learn_valid,
    input  wire l2_learn_pkg::learn_entry_t    learn_entry,
    output logic                               learn_ready,
    output logic                               fib_wr_valid,
    output l2_learn_pkg::learn_entry_t         fib_wr_entry,
    input  wire logic                          pkt_da_valid,
    input  wire l2_learn_pkg::station_addr_t   pkt_da,
    output logic                               inject_req,
    input  wire logic                          fail_valid,
    input  wire l2_learn_pkg::station_addr_t   fail_addr,
    input  wire l2_learn_pkg::fail_gid_t       fail_gid,
    input  wire l2_learn_pkg::port_num_t       fail_port,
    output logic                               wmark_pulse,
    output logic                               irq
);
    import l2_learn_pkg::*;

    localparam int CW = $clog2(DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic               aw_w_ready_q;
    logic               bvalid_q;
    axi_resp_t          bresp_q;
    logic               arready_q;
    logic               rvalid_q;
    axi_data_t          rdata_q;
    axi_resp_t          rresp_q;
    logic               commit_q;
    logic [5:0]         wmark_q;
    logic [48:0]        dest_q;
    logic [64:0]        ovf_q;
    irq_vec_t           stat_q;
    irq_vec_t           stat_d;
    irq_vec_t           mask_q;
    logic               irq_q;
    logic               wm_pulse_q;
    logic               inject_q;
    logic               fib_valid_q;
    learn_entry_t       fib_entry_q;
    logic [123:0]       snap_q;
    logic [123:0]       res_now;
    learn_entry_t       head;
    logic [CW-1:0]      count_q;
    logic [CW-1:0]      occ_after;
    logic               in_ready_q;
    logic               empty;
    logic               push;
    logic               pop;
    logic               wr_take;
    logic               rd_take;
    word_idx_t          wr_idx;
    word_idx_t          rd_idx;
    axi_data_t          wmerged;
    axi_data_t          dest_hi_m;
    axi_data_t          rd_word;
    axi_resp_t          rd_resp;
    logic               wr_hit;
    logic               ovf_clear;
    logic               ovf_capture;
    logic               wm_event;

    assign awready      = aw_w_ready_q;
    assign wready       = aw_w_ready_q;
    assign bvalid       = bvalid_q;
    assign bresp        = bresp_q;
    assign arready      = arready_q;
    assign rvalid       = rvalid_q;
    assign rdata        = rdata_q;
    assign rresp        = rresp_q;
    assign learn_ready  = in_ready_q;
    assign fib_wr_valid = fib_valid_q;
    assign fib_wr_entry = fib_entry_q;
    assign inject_req   = inject_q;
    assign wmark_pulse  = wm_pulse_q;
    assign irq          = irq_q;

    // Byte-lane merge of a write onto the current word
    function automatic axi_data_t merge_bytes(axi_data_t old, axi_data_t nw, axi_strb_t s);
        axi_data_t r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Result FIFO

    result_store #(
        .WIDTH (123),
        .DEPTH (DEPTH)
    ) u_store (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .push       (push),
        .din        (learn_entry),
        .pop        (pop),
        .head       (head),
        .count_q    (count_q),
        .in_ready_q (in_ready_q),
        .empty      (empty)
    );

    // Engine stalls on learn_ready when the FIFO is full
    assign push = learn_valid && in_ready_q;

    assign res_now = empty ? 124'h0 : {1'b1, head};

    assign pop = rd_take && (rd_idx == `IDX_RESULT) && !empty;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            snap_q <= 124'h0;
        end else if (rd_take && (rd_idx == `IDX_RESULT)) begin
            snap_q <= res_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Table write-back

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fib_valid_q <= 1'b0;
            fib_entry_q <= '0;
        end else begin
            fib_valid_q <= push && (commit_q || learn_entry[`ORIGIN_BIT]);
            if (push) begin
                fib_entry_q <= learn_entry;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Injected packet detection

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inject_q <= 1'b0;
        end else begin
            inject_q <= pkt_da_valid && dest_q[`DEST_EN_BIT] && (pkt_da == dest_q[47:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watermark and overflow events

    assign occ_after = CW'(count_q + 1'b1 - CW'(pop));
    assign wm_event  = push && (int'(occ_after) > int'(wmark_q));

    assign ovf_clear   = wr_take && (wr_idx == `IDX_OVF) && wstrb[0] && !wdata[0];
    // hold while valid, a same-cycle clear lets it in
    assign ovf_capture = fail_valid && (!ovf_q[`OVF_VALID_BIT] || ovf_clear);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_q <= `RST_OVF;
        end else if (ovf_capture) begin
            ovf_q <= {fail_port, fail_gid, fail_addr, 1'b1};
        end else if (ovf_clear) begin
            ovf_q[`OVF_VALID_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wm_pulse_q <= 1'b0;
        end else begin
            wm_pulse_q <= wm_event;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and line

    always_comb begin
        stat_d = stat_q;
        if (wr_take && (wr_idx == `IDX_IRQ_STAT)) begin
            stat_d = stat_d & ~wmerged[1:0];
        end
        // New events win over a clear in the same cycle
        stat_d[`IRQ_WM_BIT]  = stat_d[`IRQ_WM_BIT] | wm_event;
        stat_d[`IRQ_OVF_BIT] = stat_d[`IRQ_OVF_BIT] | ovf_capture;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= `RST_IRQ;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q  <= |(stat_d & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus write channel

    assign wr_idx  = awaddr[23:2];
    assign wr_take = awvalid && wvalid && aw_w_ready_q;
    assign wmerged = merge_bytes(32'h0, wdata, wstrb);
    assign dest_hi_m = merge_bytes({15'h0, dest_q[48:32]}, wdata, wstrb);

    always_comb begin
        unique case (wr_idx)
            `IDX_OVF, `IDX_OVF + 22'h1, `IDX_OVF + 22'h2, `IDX_OVF + 22'h3,
            `IDX_CTRL, `IDX_WMARK, `IDX_IRQ_STAT, `IDX_IRQ_MASK,
            `IDX_DEST, `IDX_DEST + 22'h1: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_w_ready_q <= 1'b0;
            bvalid_q     <= 1'b0;
            bresp_q      <= `RESP_OKAY;
        end else begin
            // Both channels taken together, one write in flight
            aw_w_ready_q <= awvalid && wvalid && !aw_w_ready_q && !bvalid_q;
            if (wr_take) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            commit_q <= `RST_CTRL;
            wmark_q  <= `RST_WMARK;
            dest_q   <= `RST_DEST;
            mask_q   <= `RST_IRQ;
        end else if (wr_take) begin
            if (wr_idx == `IDX_CTRL && wstrb[0]) begin
                commit_q <= wdata[0];
            end
            if (wr_idx == `IDX_WMARK && wstrb[0]) begin
                wmark_q <= wdata[5:0];
            end
            if (wr_idx == `IDX_IRQ_MASK && wstrb[0]) begin
                mask_q <= wdata[1:0];
            end
            if (wr_idx == `IDX_DEST) begin
                dest_q[31:0] <= merge_bytes(dest_q[31:0], wdata, wstrb);
            end
            if (wr_idx == `IDX_DEST + 22'h1) begin
                dest_q[48:32] <= dest_hi_m[16:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus read channel

    assign rd_idx  = araddr[23:2];
    assign rd_take = arvalid && arready_q;

    // Words after the first come from the snapshot taken at the pop
    always_comb begin
        rd_word = 32'h0;
        rd_resp = `RESP_OKAY;
        unique case (rd_idx)
            `IDX_OVF:              rd_word = ovf_q[31:0];
            `IDX_OVF + 22'h1:      rd_word = ovf_q[63:32];
            `IDX_OVF + 22'h2:      rd_word = {31'h0, ovf_q[64]};
            `IDX_OVF + 22'h3:      rd_word = 32'h0;
            `IDX_CTRL:             rd_word = {31'h0, commit_q};
            `IDX_WMARK:            rd_word = {26'h0, wmark_q};
            `IDX_IRQ_STAT:         rd_word = {30'h0, stat_q};
            `IDX_IRQ_MASK:         rd_word = {30'h0, mask_q};
            `IDX_RESULT:           rd_word = res_now[31:0];
            `IDX_RESULT + 22'h1:   rd_word = snap_q[63:32];
            `IDX_RESULT + 22'h2:   rd_word = snap_q[95:64];
            `IDX_RESULT + 22'h3:   rd_word = {4'h0, snap_q[123:96]};
            `IDX_DEST:             rd_word = dest_q[31:0];
            `IDX_DEST + 22'h1:     rd_word = {15'h0, dest_q[48:32]};
            default:               rd_resp = `RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= `RESP_OKAY;
        end else begin
            arready_q <= arvalid && !arready_q && !rvalid_q;
            if (rd_take) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_word;
                rresp_q  <= rd_resp;
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
endmodule

// file: l2_learning_report_fifo_checker.sv
`timescale 1ns/1ps
module l2_learning_report_fifo_checker #(
    parameter int DEPTH = 64
) (
    input wire logic                       aclk,
    input wire logic                       aresetn,
    input wire logic                       awvalid,
    input wire logic                       awready,
    input wire logic                       wvalid,
    input wire logic                       wready,
    input wire l2_learn_pkg::axi_resp_t    bresp,
    input wire logic                       bvalid,
    input wire logic                       bready,
    input wire logic                       arvalid,
    input wire logic                       arready,
    input wire l2_learn_pkg::axi_data_t    rdata,
    input wire l2_learn_pkg::axi_resp_t    rresp,
    input wire logic                       rvalid,
    input wire logic                       rready,
    input wire logic                       learn_valid,
    input wire l2_learn_pkg::learn_entry_t learn_entry,
    input wire logic                       learn_ready,
    input wire logic                       fib_wr_valid,
    input wire l2_learn_pkg::learn_entry_t fib_wr_entry,
    input wire logic                       pkt_da_valid,
    input wire logic                       inject_req,
    input wire logic                       wmark_pulse
);
    import l2_learn_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_push; learn_valid && learn_ready; endsequence
    sequence s_rd_take; arvalid && arready; endsequence
    property p_sw_commit; s_push ##0 learn_entry[122] |=>
        fib_wr_valid && fib_wr_entry == $past(learn_entry); endproperty
    a_sw_commit: assert property (p_sw_commit)
        else $error("injected result not written to table");
    property p_commit_cause; fib_wr_valid |-> $past(learn_valid && learn_ready); endproperty
    a_commit_cause: assert property (p_commit_cause)
        else $error("table write without a push");
    property p_wmark_cause; wmark_pulse |-> $past(learn_valid && learn_ready); endproperty
    a_wmark_cause: assert property (p_wmark_cause)
        else $error("watermark pulse without a push");
    property p_wmark_once; wmark_pulse && !(learn_valid && learn_ready) |=> !wmark_pulse;
    endproperty
    a_wmark_once: assert property (p_wmark_once)
        else $error("watermark pulse longer than one cycle");
    property p_inject_cause; inject_req |-> $past(pkt_da_valid); endproperty
    a_inject_cause: assert property (p_inject_cause)
        else $error("inject request without a packet");
    property p_rd_answer; s_rd_take |=> rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read answer late");
    property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_rhold: assert property (p_rhold)
        else $error("read answer changed before taken");
    property p_wr_answer; awvalid && awready && wvalid |=> bvalid; endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write answer late");
    property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_bhold: assert property (p_bhold)
        else $error("write answer changed before taken");
    property p_aw_w; awready |-> wready && awvalid && wvalid; endproperty
    a_aw_w: assert property (p_aw_w)
        else $error("address and data not taken together");
endmodule

// file: l2_learning_report_fifo_tb_top.sv
`timescale 1ns/1ps
`include "l2_learn_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module l2_learning_report_fifo_tb_top;
    import l2_learn_pkg::*;
    localparam int DEPTH = 4;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, learn_valid, learn_ready;
    logic fib_wr_valid, pkt_da_valid, inject_req, fail_valid, wmark_pulse, irq;
    axi_addr_t     awaddr, araddr;
    axi_data_t     wdata, rdata, rd;
    axi_strb_t     wstrb;
    axi_resp_t     bresp, rresp, resp;
    learn_entry_t  learn_entry, fib_wr_entry;
    station_addr_t pkt_da, fail_addr;
    fail_gid_t     fail_gid;
    port_num_t     fail_port;
    int            errors = 0;
    int            checks = 0;
    int            cycles = 0;
    l2_learning_report_fifo #(.DEPTH(DEPTH)) dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .learn_valid(learn_valid),
        .learn_entry(learn_entry), .learn_ready(learn_ready),
        .fib_wr_valid(fib_wr_valid), .fib_wr_entry(fib_wr_entry),
        .pkt_da_valid(pkt_da_valid), .pkt_da(pkt_da), .inject_req(inject_req),
        .fail_valid(fail_valid), .fail_addr(fail_addr), .fail_gid(fail_gid),
        .fail_port(fail_port), .wmark_pulse(wmark_pulse), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input word_idx_t idx, input axi_data_t d);
        @(posedge aclk);
        awaddr <= {idx, 2'b00}; wdata <= d; wstrb <= 4'hf;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0; wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdw(input word_idx_t idx);
        @(posedge aclk);
        araddr <= {idx, 2'b00}; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata; resp = rresp;
        rready <= 1'b0;
    endtask
    // Word 0 first: it pops and snapshots the rest
    task automatic rdres(output logic [127:0] w);
        for (int k = 0; k < 4; k++) begin
            rdw(`IDX_RESULT + 22'(k)); w[32*k +: 32] = rd;
        end
    endtask
    task automatic rdovf(output logic [95:0] w);
        for (int k = 0; k < 3; k++) begin
            rdw(`IDX_OVF + 22'(k)); w[32*k +: 32] = rd;
        end
    endtask
    function automatic learn_entry_t mk(input logic sw, input logic [7:0] i);
        return {sw, 26'h2a5a5a5 ^ {18'h0, i}, 48'hfedc_ba98_7654 ^ {40'h0, i},
                48'h1111_2222_3333 + {40'h0, i}};
    endfunction
    task automatic push(input learn_entry_t e, output logic fv, output logic wm,
                        output learn_entry_t fe);
        @(posedge aclk);
        learn_valid <= 1'b1; learn_entry <= e;
        do @(posedge aclk); while (learn_ready !== 1'b1);
        learn_valid <= 1'b0;
        @(posedge aclk);
        fv = fib_wr_valid; wm = wmark_pulse; fe = fib_wr_entry;
    endtask
    task automatic probe(input station_addr_t a, input logic exp);
        @(posedge aclk);
        pkt_da_valid <= 1'b1; pkt_da <= a;
        @(posedge aclk);
        pkt_da_valid <= 1'b0;
        @(posedge aclk);
        `CHK(inject_req, exp)
    endtask
    task automatic fail(input station_addr_t a, input fail_gid_t g, input port_num_t p);
        @(posedge aclk);
        fail_valid <= 1'b1; fail_addr <= a; fail_gid <= g; fail_port <= p;
        @(posedge aclk);
        fail_valid <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        logic [127:0] w;
        rdw(`IDX_CTRL); `CHK(rd, 32'h1)
        rdw(`IDX_WMARK); `CHK(rd, 32'h0)
        rdw(`IDX_DEST + 22'h1); `CHK(rd, 32'h0)
        rdw(`IDX_OVF); `CHK(rd, 32'h0)
        rdw(22'h000001); `CHK(resp, `RESP_SLVERR)
        wr(22'h000001, 32'hffff_ffff); `CHK(resp, `RESP_SLVERR)
        rdres(w); `CHK(w[123:0], 124'h0)
    endtask
    task automatic t_inject;
        probe(48'h0, 1'b0);
        wr(`IDX_DEST, 32'h89ab_cdef);
        wr(`IDX_DEST + 22'h1, 32'h0001_4567);
        probe(48'h4567_89ab_cdef, 1'b1);
        probe(48'h4567_89ab_cdee, 1'b0);
        wr(`IDX_DEST + 22'h1, 32'h0000_4567);
        probe(48'h4567_89ab_cdef, 1'b0);
    endtask
    // Fill to refusal with level one, drain in order, then an empty read
    task automatic t_fifo;
        logic fv, wm;
        learn_entry_t fe;
        logic [127:0] w;
        wr(`IDX_WMARK, 32'h1);
        wr(`IDX_IRQ_MASK, 32'h1);
        for (int i = 0; i < DEPTH; i++) begin
            push(mk(1'b0, 8'(i)), fv, wm, fe);
            `CHK(fv, 1'b1)
            `CHK(fe, mk(1'b0, 8'(i)))
            `CHK(wm, logic'(i >= 1))
        end
        `CHK(irq, 1'b1)
        @(posedge aclk);
        learn_valid <= 1'b1; learn_entry <= mk(1'b1, 8'h99);
        repeat (3) @(posedge aclk);
        `CHK(learn_ready, 1'b0)
        learn_valid <= 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            rdres(w); `CHK(w[123:0], {1'b1, mk(1'b0, 8'(i))})
        end
        rdres(w); `CHK(w[123:0], 124'h0)
        wr(`IDX_IRQ_STAT, 32'h1);
        @(posedge aclk);
        `CHK(irq, 1'b0)
    endtask
    // Level wider than the count: no pulse may come
    task automatic t_writeback;
        logic fv, wm;
        learn_entry_t fe, e;
        logic [127:0] w;
        wr(`IDX_WMARK, 32'h8);
        wr(`IDX_CTRL, 32'h0);
        push(mk(1'b0, 8'h20), fv, wm, fe); `CHK(fv, 1'b0)
        `CHK(wm, 1'b0)
        push(mk(1'b1, 8'h21), fv, wm, fe); `CHK(fv, 1'b1)
        `CHK(wm, 1'b0)
        rdres(w); `CHK(w[123:0], {1'b1, mk(1'b0, 8'h20)})
        rdres(w); `CHK(w[123:0], {1'b1, mk(1'b1, 8'h21)})
        e = mk(1'b1, 8'h21);
        `CHK(w[78:64], e[78:64])
        `CHK(w[89:79], e[89:79])
        `CHK(w[118:90], e[118:90])
        `CHK(w[121:119], e[121:119])
        wr(`IDX_CTRL, 32'h1);
    endtask
    // Second failure must not disturb a pending record
    task automatic t_overflow;
        logic [95:0] w;
        fail(48'ha1a2_a3a4_a5a6, 12'h5c3, 4'h9);
        rdovf(w); `CHK(w[64:0], {4'h9, 12'h5c3, 48'ha1a2_a3a4_a5a6, 1'b1})
        rdw(`IDX_IRQ_STAT); `CHK(rd[1], 1'b1)
        fail(48'h0b0c_0d0e_0f10, 12'h111, 4'h2);
        rdovf(w); `CHK(w[64:0], {4'h9, 12'h5c3, 48'ha1a2_a3a4_a5a6, 1'b1})
        wr(`IDX_OVF, 32'h0);
        rdw(`IDX_OVF); `CHK(rd[0], 1'b0)
        fail(48'h0b0c_0d0e_0f10, 12'h111, 4'h2);
        rdovf(w); `CHK(w[64:0], {4'h2, 12'h111, 48'h0b0c_0d0e_0f10, 1'b1})
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        aresetn = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0;
        wvalid = 1'b0; bready = 1'b0; araddr = '0; arvalid = 1'b0; rready = 1'b0;
        learn_valid = 1'b0; learn_entry = '0; pkt_da_valid = 1'b0; pkt_da = '0;
        fail_valid = 1'b0; fail_addr = '0; fail_gid = '0; fail_port = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_values();
        t_inject();
        t_fifo();
        t_writeback();
        t_overflow();
        summarize();
    end
endmodule
bind l2_learning_report_fifo l2_learning_report_fifo_checker #(.DEPTH(DEPTH)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .learn_valid(learn_valid),
    .learn_entry(learn_entry), .learn_ready(learn_ready), .fib_wr_valid(fib_wr_valid),
    .fib_wr_entry(fib_wr_entry), .pkt_da_valid(pkt_da_valid), .inject_req(inject_req),
    .wmark_pulse(wmark_pulse));
